// [fsr_host_model.sv]
/* Host model on the fsr_status link port.
   Assumes one bench process calls xfer at a time. */
`timescale 1ns/1ps
module fsr_host_model (
  input  wire logic        link_clk,
  input  wire logic        cmd_ready,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  output logic             cmd_valid,
  output logic [7:0]       cmd_code
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
  end
  // Poke keeps offering one cycle after the take
  task automatic xfer(input logic [7:0] c, input bit poke,
    output logic [15:0] d, output bit ok);
    int n;
    ok = 0;
    d = 16'h0000;
    @(posedge link_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    n = 0;
    do begin
      @(posedge link_clk);
      n++;
    end while (!cmd_ready && n < 20);
    if (!cmd_ready) return;
    cmd_valid <= poke;
    cmd_code <= ~c;
    for (n = 0; n < 30 && !ok; n++) begin
      @(posedge link_clk);
      cmd_valid <= 1'b0;
      if (rsp_valid) begin
        d = rsp_data;
        ok = 1;
      end
    end
  endtask
endmodule

// [fsr_pkg.sv]
/*
  Constants for the fault and summary status block, plus the
  two-flop level synchroniser that the block instantiates.
  Assumes one system clock domain and one link clock domain.
*/
package fsr_pkg;
  // Command codes seen on the serial link
  localparam logic [7:0] FSR_CMD_OPERATION    = 8'h01;
  localparam logic [7:0] FSR_CMD_ON_OFF_CFG   = 8'h02;
  localparam logic [7:0] FSR_CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] FSR_CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] FSR_CMD_SUMMARY_WORD = 8'h79;

  // Summary word bit positions
  localparam int FSR_B_VOUT      = 15;
  localparam int FSR_B_IOUT      = 14;
  localparam int FSR_B_INPUT     = 13;
  localparam int FSR_B_MFR       = 12;
  localparam int FSR_B_PNOTGOOD  = 11;
  localparam int FSR_B_FANS      = 10;
  localparam int FSR_B_OTHER     = 9;
  localparam int FSR_B_UNKNOWN   = 8;
  localparam int FSR_B_BUSY      = 7;
  localparam int FSR_B_OFF       = 6;
  localparam int FSR_B_VOUT_OV   = 5;
  localparam int FSR_B_IOUT_OC   = 4;
  localparam int FSR_B_VIN_UV    = 3;
  localparam int FSR_B_TEMP      = 2;
  localparam int FSR_B_CML       = 1;
  localparam int FSR_B_HIGH_BYTE = 0;

  // Detailed register bit positions used by the summary
  localparam int FSR_VOUT_OV_FAULT   = 7;
  localparam int FSR_VOUT_TON_MAX    = 2;
  localparam int FSR_INPUT_UV_FAULT  = 4;

  // Detailed status indices
  localparam int FSR_DET_VOUT  = 0;
  localparam int FSR_DET_INPUT = 1;
  localparam int FSR_DET_TEMP  = 2;
  localparam int FSR_DET_CML   = 3;
  localparam int FSR_DET_MFR   = 4;
  localparam int FSR_NUM_DET   = 5;

  localparam logic [7:0]  FSR_BYTE_ZERO = 8'h00;
  localparam logic [15:0] FSR_WORD_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    FSR_LNK_IDLE,
    FSR_LNK_WAIT
  } fsr_lnk_state_t;
endpackage

`timescale 1ns/1ps
module fsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// [fsr_status.sv]
/*
  Fault latching and summary status for one supply channel.
  Link side runs on link_clk; commands cross to sys_clk by a
  toggle handshake, and the answer word returns stable under it.
  Fault events and detailed causes come from logic on sys_clk.
*/
`timescale 1ns/1ps
// What this block does
// R01 - Shutdown fault latches channel off
// R02 - Pin toggle, on/off commands, bias cycle release
// R03 - Any event pulls alert low, sets bits
// R04 - Clear faults wipes status, keeps latch
// R05 - Status byte equals word low byte
// R06 - Status word gives sixteen summary bits
// R07 - Bit 15 reports output voltage events
// R08 - Unsupported summary bits read zero
// R09 - Bit 13 reports input voltage events
// R10 - Bit 12 reports manufacturer faults
// R11 - Bit 11 reports enabled power-good negated
// R12 - Bit 7 flags command while busy
// R13 - Bit 6 set whenever output unpowered
// R14 - Bit 5 reports output overvoltage fault
// R15 - Bit 3 reports input undervoltage fault
// R16 - Bit 2 reports temperature events
// R17 - Bit 1 reports comms/memory/logic faults
// R18 - Bit 0 reports events outside bits 7..1
// R19 - Host rechecks other channels after clearing
// R20 - Start-up timeout sets vout and high-byte
// R21 - Status bits other than bits 11 and 6 stay until cleared
module fsr_status
  import fsr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  input  wire logic        control_pin,
  input  wire logic        bias_sense_input,
  input  wire logic        shutdown_fault,
  input  wire logic        ton_max_fault,
  input  wire logic [7:0]  vout_evt,
  input  wire logic [7:0]  input_evt,
  input  wire logic [7:0]  temp_evt,
  input  wire logic [7:0]  cml_evt,
  input  wire logic [7:0]  mfr_evt,
  input  wire logic        chan_enable,
  input  wire logic        pg_enable,
  input  wire logic        power_good_output,
  output logic             chan_latched_off,
  output logic             fault_alert_line_n_out,
  output logic             fault_alert_line_n_oe
);

  function automatic logic is_release_cmd(input logic [7:0] c);
    is_release_cmd = (c == FSR_CMD_OPERATION) ||
                     (c == FSR_CMD_ON_OFF_CFG);
  endfunction

  // ---------------- Link domain ----------------
  fsr_lnk_state_t lnk_state;
  logic [7:0]     lnk_code;
  logic           lnk_req_tgl;
  logic           lnk_busy_tgl;
  logic           lnk_ack_s;
  logic           lnk_ack_d;
  logic [15:0]    ans_word;
  logic           sys_ack_tgl;

  wire lnk_ack_evt = lnk_ack_s ^ lnk_ack_d;
  wire lnk_take    = cmd_valid && (lnk_state == FSR_LNK_IDLE);
  wire lnk_busy    = cmd_valid && (lnk_state != FSR_LNK_IDLE);

  assign cmd_ready = (lnk_state == FSR_LNK_IDLE);

  fsr_sync #(.W(1)) u_ack_sync (
    .clk   (link_clk),
    .rst_n (rst_n),
    .d     (sys_ack_tgl),
    .q     (lnk_ack_s)
  );

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk_state    <= FSR_LNK_IDLE;
      lnk_code     <= FSR_BYTE_ZERO;
      lnk_req_tgl  <= 1'b0;
      lnk_busy_tgl <= 1'b0;
      lnk_ack_d    <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_data     <= FSR_WORD_ZERO;
    end else begin
      lnk_ack_d <= lnk_ack_s;
      rsp_valid <= 1'b0;
      if (lnk_busy)
        lnk_busy_tgl <= ~lnk_busy_tgl; // R12
      case (lnk_state)
        FSR_LNK_IDLE: begin
          if (lnk_take) begin
            lnk_code    <= cmd_code;
            lnk_req_tgl <= ~lnk_req_tgl;
            lnk_state   <= FSR_LNK_WAIT;
          end
        end
        FSR_LNK_WAIT: begin
          if (lnk_ack_evt) begin
            // Answer word is held stable while ack is in flight
            rsp_data  <= ans_word;
            rsp_valid <= 1'b1;
            lnk_state <= FSR_LNK_IDLE;
          end
        end
        default: lnk_state <= FSR_LNK_IDLE;
      endcase
    end
  end

  // ---------------- System domain ----------------
  logic       req_s;
  logic       req_d;
  logic       busy_s;
  logic       busy_d;
  logic       ctl_s;
  logic       ctl_d;
  logic       bias_s;
  logic       bias_d;
  logic [7:0] det [FSR_NUM_DET];
  logic       busy_st;
  logic       hb_st;
  logic       alert;
  logic       latched;

  fsr_sync #(.W(4)) u_sys_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     ({lnk_req_tgl, lnk_busy_tgl, control_pin, bias_sense_input}),
    .q     ({req_s, busy_s, ctl_s, bias_s})
  );

  wire req_evt   = req_s ^ req_d;
  wire busy_evt  = busy_s ^ busy_d;
  wire cmd_clear = req_evt && (lnk_code == FSR_CMD_CLEAR_FAULTS);
  wire cmd_rel   = req_evt && is_release_cmd(lnk_code);
  wire pin_tgl   = ctl_s ^ ctl_d;
  wire bias_up   = bias_s && !bias_d;
  wire release_l = pin_tgl || cmd_rel || bias_up; // R02
  wire clear_st  = cmd_clear || release_l; // R04 R21

  wire [7:0] vout_in = vout_evt |
    (ton_max_fault ? (8'h01 << FSR_VOUT_TON_MAX) : FSR_BYTE_ZERO); // R20

  wire [7:0] det_in [FSR_NUM_DET];
  assign det_in[FSR_DET_VOUT]  = vout_in;
  assign det_in[FSR_DET_INPUT] = input_evt;
  assign det_in[FSR_DET_TEMP]  = temp_evt;
  assign det_in[FSR_DET_CML]   = cml_evt;
  assign det_in[FSR_DET_MFR]   = mfr_evt;

  wire pnotgood = pg_enable && !power_good_output; // R11

  // Causes outside the low byte's own bits
  wire [7:0] vout_hb_mask  = ~(8'h01 << FSR_VOUT_OV_FAULT);
  wire [7:0] input_hb_mask = ~(8'h01 << FSR_INPUT_UV_FAULT);
  wire hb_evt = |(vout_in & vout_hb_mask) |
                |(input_evt & input_hb_mask) |
                |mfr_evt | pnotgood; // R18 R20
  wire any_evt = (|vout_in) | (|input_evt) | (|temp_evt) |
                 (|cml_evt) | (|mfr_evt) | shutdown_fault |
                 busy_evt | pnotgood; // R03

  genvar gi;
  generate
    for (gi = 0; gi < FSR_NUM_DET; gi++) begin : g_det
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
          det[gi] <= FSR_BYTE_ZERO;
        else
          det[gi] <= (det[gi] & ~{8{clear_st}}) | det_in[gi]; // R03 R21
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_d   <= 1'b0;
      busy_d  <= 1'b0;
      ctl_d   <= 1'b0;
      bias_d  <= 1'b0;
      busy_st <= 1'b0;
      hb_st   <= 1'b0;
      alert   <= 1'b0;
      latched <= 1'b0;
    end else begin
      req_d   <= req_s;
      busy_d  <= busy_s;
      ctl_d   <= ctl_s;
      bias_d  <= bias_s;
      busy_st <= (busy_st && !clear_st) || busy_evt; // R12 R21
      hb_st   <= (hb_st && !clear_st) || hb_evt; // R18 R21
      alert   <= (alert && !clear_st) || any_evt; // R03 R04
      // Set wins; clear faults alone never releases
      latched <= (latched && !release_l) || shutdown_fault; // R01 R04
    end
  end

  logic [15:0] word;
  always_comb begin
    word                  = FSR_WORD_ZERO; // R08
    word[FSR_B_VOUT]      = |det[FSR_DET_VOUT]; // R07
    word[FSR_B_INPUT]     = |det[FSR_DET_INPUT]; // R09
    word[FSR_B_MFR]       = |det[FSR_DET_MFR]; // R10
    word[FSR_B_PNOTGOOD]  = pnotgood; // R11
    word[FSR_B_BUSY]      = busy_st; // R12
    word[FSR_B_OFF]       = !(chan_enable && !latched); // R13
    word[FSR_B_VOUT_OV]   = det[FSR_DET_VOUT][FSR_VOUT_OV_FAULT]; // R14
    word[FSR_B_VIN_UV]    = det[FSR_DET_INPUT][FSR_INPUT_UV_FAULT]; // R15
    word[FSR_B_TEMP]      = |det[FSR_DET_TEMP]; // R16
    word[FSR_B_CML]       = |det[FSR_DET_CML]; // R17
    word[FSR_B_HIGH_BYTE] = hb_st; // R18
  end

  // Byte read returns the same low byte, upper byte zero
  wire [15:0] next_ans = (lnk_code == FSR_CMD_SUMMARY_BYTE) ?
                         {FSR_BYTE_ZERO, word[7:0]} : word; // R05 R06

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ans_word    <= FSR_WORD_ZERO;
      sys_ack_tgl <= 1'b0;
    end else if (req_evt) begin
      ans_word    <= next_ans;
      sys_ack_tgl <= ~sys_ack_tgl;
    end
  end

  assign chan_latched_off       = latched;
  assign fault_alert_line_n_out = 1'b0;
  assign fault_alert_line_n_oe  = alert; // R03
endmodule

// [fsr_status_sva.sv]
/* Assertions on the fsr_status ports.
   Assumes the bind below reaches every fsr_status. */
`timescale 1ns/1ps
module fsr_status_sva (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        link_clk,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic        shutdown_fault,
  input wire logic        ton_max_fault,
  input wire logic [7:0]  vout_evt,
  input wire logic        chan_latched_off,
  input wire logic        fault_alert_line_n_out,
  input wire logic        fault_alert_line_n_oe
);
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_answer;
    !cmd_ready [*2] ##[1:12] rsp_valid;
  endsequence
  a_answer_in_time: assert property (@(posedge link_clk)
    disable iff (!rst_n) s_take |=> s_answer) else $error("no answer");
  a_rsp_one_cycle: assert property (@(posedge link_clk)
    disable iff (!rst_n) rsp_valid |=> !rsp_valid) else $error("rsp long");
  a_ready_after: assert property (@(posedge link_clk)
    disable iff (!rst_n) rsp_valid |-> ##[0:1] cmd_ready)
    else $error("ready stuck");
  a_unsup_zero: assert property (@(posedge link_clk)
    disable iff (!rst_n) rsp_valid |-> (rsp_data & 16'h4710) == 16'h0000)
    else $error("unsupported bit set");
  a_alert_low: assert property (@(posedge sys_clk)
    disable iff (!rst_n) fault_alert_line_n_out == 1'b0)
    else $error("alert level");
  a_shut_latch: assert property (@(posedge sys_clk)
    disable iff (!rst_n) shutdown_fault |=> chan_latched_off)
    else $error("no latch");
  a_vout_alert: assert property (@(posedge sys_clk)
    disable iff (!rst_n) vout_evt != 8'h00 |=> fault_alert_line_n_oe)
    else $error("no alert");
  a_ton_alert: assert property (@(posedge sys_clk)
    disable iff (!rst_n) ton_max_fault |=> fault_alert_line_n_oe)
    else $error("no alert on timeout");
endmodule

bind fsr_status fsr_status_sva u_sva (.sys_clk, .rst_n, .link_clk,
  .cmd_valid, .cmd_ready, .rsp_valid, .rsp_data, .shutdown_fault,
  .ton_max_fault, .vout_evt, .chan_latched_off, .fault_alert_line_n_out,
  .fault_alert_line_n_oe);

// [fsr_status_tb_top.sv]
/* Bench for fsr_status with a host model and a word model.
   Assumes it is the only top module. */
`timescale 1ns/1ps
module fsr_status_tb_top;
  import fsr_pkg::*;
  logic        sys_clk = 0, link_clk = 0, rst_n = 0, lat = 0;
  logic        cmd_valid, cmd_ready, rsp_valid, chan_latched_off;
  logic        fault_alert_line_n_out, fault_alert_line_n_oe;
  logic [7:0]  cmd_code, v;
  logic [15:0] rsp_data, d, st = 16'h0000;
  logic        control_pin = 0, bias_sense_input = 1;
  logic        shutdown_fault = 0, ton_max_fault = 0, chan_enable = 0;
  logic        pg_enable = 0, power_good_output = 0;
  logic [7:0]  ev [5] = '{default: 8'h00};
  logic [15:0] hi [5] = '{16'h8000, 16'h2000, 16'h0004, 16'h0002, 16'h1000};
  logic [7:0]  lo [5] = '{8'h7F, 8'hEF, 8'h00, 8'h00, 8'hFF};
  int          err_count = 0, cmp_count = 0;
  int unsigned seed = 92753;

  always #5 sys_clk = ~sys_clk;
  initial begin
    #3;
    forever #16 link_clk = ~link_clk;
  end

  fsr_status DUT (.sys_clk, .rst_n, .link_clk, .cmd_valid, .cmd_code,
    .cmd_ready, .rsp_valid, .rsp_data, .control_pin, .bias_sense_input,
    .shutdown_fault, .ton_max_fault, .vout_evt(ev[0]), .input_evt(ev[1]),
    .temp_evt(ev[2]), .cml_evt(ev[3]), .mfr_evt(ev[4]), .chan_enable,
    .pg_enable, .power_good_output, .chan_latched_off,
    .fault_alert_line_n_out, .fault_alert_line_n_oe);
  fsr_host_model host (.link_clk, .cmd_ready, .rsp_valid, .rsp_data,
    .cmd_valid, .cmd_code);

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [15:0] ew();
    logic [15:0] w;
    w = st;
    if (!chan_enable || lat) w |= 16'h0040;
    if (pg_enable && !power_good_output) w |= 16'h0801;
    return w;
  endfunction
  task automatic xf(input logic [7:0] c, input bit poke);
    bit ok;
    host.xfer(c, poke, d, ok);
    if (!ok) begin
      err_count++;
      finish_test();
    end
    // Back onto the falling system edge before driving anything else
    cyc(1);
  endtask
  task automatic rw();
    logic [15:0] w;
    w = ew();
    xf(FSR_CMD_SUMMARY_WORD, 0);
    chk(d, w);
    xf(FSR_CMD_SUMMARY_BYTE, 0);
    chk(d, {8'h00, w[7:0]});
  endtask
  task automatic cmd(input logic [7:0] c);
    xf(c, 0);
    st = 16'h0000;
    if (c != FSR_CMD_CLEAR_FAULTS) lat = 0;
  endtask

  initial begin
    cyc(6);
    rst_n = 1;
    cyc(3);
    rw();
    chan_enable = 1;
    cyc(3);
    rw();
    for (int i = 0; i < 5; i++) begin
      v = (rnd() & 8'hE0) | 8'h10;
      ev[i] = v;
      cyc(1);
      ev[i] = 8'h00;
      cyc(2);
      st |= hi[i];
      if (i == 0 && v[7]) st |= 16'h0020;
      if (i == 1 && v[4]) st |= 16'h0008;
      if ((v & lo[i]) != 8'h00) st |= 16'h0001;
      chk(fault_alert_line_n_oe, 1'b1);
      rw();
      cmd(FSR_CMD_CLEAR_FAULTS);
      rw();
      chk(fault_alert_line_n_oe, 1'b0);
    end
    $display("event test done");
    xf(FSR_CMD_SUMMARY_WORD, 1);
    st |= 16'h0080;
    cyc(3);
    rw();
    cmd(FSR_CMD_CLEAR_FAULTS);
    $display("busy test done");
    for (int k = 0; k < 4; k++) begin
      shutdown_fault = 1;
      cyc(1);
      shutdown_fault = 0;
      cyc(4);
      lat = 1;
      chk(chan_latched_off, 1'b1);
      cmd(FSR_CMD_CLEAR_FAULTS);
      chk(chan_latched_off, 1'b1);
      rw();
      if (k == 0) cmd(FSR_CMD_OPERATION);
      if (k == 1) control_pin = ~control_pin;
      if (k == 2) bias_sense_input = 0;
      if (k == 3) cmd(FSR_CMD_ON_OFF_CFG);
      cyc(5);
      bias_sense_input = 1;
      cyc(5);
      lat = 0;
      st = 16'h0000;
      chk(chan_latched_off, 1'b0);
      rw();
    end
    $display("latch test done");
    ton_max_fault = 1;
    cyc(1);
    ton_max_fault = 0;
    cyc(2);
    st |= 16'h8001;
    chk(fault_alert_line_n_oe, 1'b1);
    rw();
    cmd(FSR_CMD_CLEAR_FAULTS);
    pg_enable = 1;
    cyc(3);
    st |= 16'h0001;
    rw();
    power_good_output = 1;
    cyc(3);
    rw();
    pg_enable = 0;
    cmd(FSR_CMD_CLEAR_FAULTS);
    rw();
    $display("power test done");
    finish_test();
  end
endmodule
